// file: src/hsq_defines.vh
// constants of the homing sequencer
`ifndef HSQ_DEFINES_VH
`define HSQ_DEFINES_VH
`define HSQ_ADDR_W        8
`define HSQ_REG_CTRL      8'h00
`define HSQ_REG_FAST      8'h04
`define HSQ_REG_SLOW      8'h08
`define HSQ_REG_ACCEL     8'h0c
`define HSQ_REG_HOME      8'h10
`define HSQ_REG_STATUS    8'h14
`define HSQ_REG_POS       8'h18
`define HSQ_REG_NODE      8'h1c
`define HSQ_CTRL_START    0
`define HSQ_CTRL_METH_LSB 8
`define HSQ_METH_W        6
`define HSQ_RST_METH      6'h00
`define HSQ_RST_SPEED     16'h0000
`define HSQ_RST_ACCEL     16'h0000
`define HSQ_RST_HOME      32'h00000000
`define HSQ_IP_PREFIX     24'hc0a864
`define HSQ_NO_INDEX_OFS  6'h10
`define HSQ_M_INDEX_MAX   6'h0e
`define HSQ_M_NOIDX_MIN   6'h11
`define HSQ_M_NOIDX_MAX   6'h1e
`define HSQ_M_IDX_NEG     6'h21
`define HSQ_M_IDX_POS     6'h22
`define HSQ_M_SET_POS     6'h23
`define HSQ_SW_NONE       2'h0
`define HSQ_SW_NEG        2'h1
`define HSQ_SW_POS        2'h2
`define HSQ_SW_HOME       2'h3
`endif

// file: src/hsq_homing_sequencer.v
// homing sequencer: method decode, search motion and home capture
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - method 1: run negative until negative limit toggles, reverse, home on index
// - method 2: run positive until positive limit toggles, reverse, home on index
// - methods 3/4: start direction from home switch level, fixed final approach
// - methods 5/6 mirror methods 3/4 on the negative-side home switch
// - methods 7-14 home on index beside home switch edge, limits used too
// - methods 7-10 use positive limit, start positive when outside home region
// - inside home region: 7/8 start left, 9/10 start right
// - in each pair one method takes the index left, the other right
// - methods 11-14 like 7-10 with negative limit, start left outside region
// - methods 17-30 repeat 1-14, home taken at the switch edge
// - methods 19/20 move as 3/4 and capture on home switch edge
// - 33 seeks nearest index negative, 34 positive, no switches
// - method 35 only loads position with the home value, no motion
// - switch inputs: high is active, low is inactive
// - node address is 192.168.100 plus the rotary/pin octet
// - at home the measured position becomes zero, later travel counts on
// - fast speed while seeking switch, slow speed while seeking index
// - one acceleration value for all homing moves
`include "hsq_defines.vh"
module hsq_homing_sequencer
(
  input  wire                   I_CORE_CLK,
  input  wire                   I_RESETN,
  input  wire [`HSQ_ADDR_W-1:0] I_ADDR,
  input  wire [31:0]            I_WDATA,
  input  wire                   I_WR,
  input  wire                   I_RD,
  output reg  [31:0]            O_RDATA,
  input  wire                   I_INDEX,
  input  wire                   I_HOME_SW,
  input  wire                   I_POS_LIM,
  input  wire                   I_NEG_LIM,
  input  wire                   I_ENC_STEP,
  input  wire                   I_ENC_DIR,
  input  wire [7:0]             I_NODE_SW,
  output wire                   O_MOVE_EN,
  output reg                    O_MOVE_DIR,
  output reg  [15:0]            O_SPEED,
  output reg  [15:0]            O_ACCEL,
  output reg  [31:0]            O_POSITION,
  output reg                    O_HOME_DONE,
  output reg                    O_HOME_ERR
);
  localparam ST_IDLE = 5'h01;
  localparam ST_SEEK = 5'h02;
  localparam ST_APPR = 5'h04;
  localparam ST_DONE = 5'h08;
  localparam ST_ERR  = 5'h10;
  localparam NPIN    = 14;

  // ******************************************
  // pin synchronisers
  // ******************************************
  wire [NPIN-1:0] pin_raw;
  reg  [NPIN-1:0] s1_r;
  reg  [NPIN-1:0] s2_r;
  reg  [NPIN-1:0] s3_r;
  reg  [NPIN-1:0] pin_r;
  assign pin_raw = {I_NODE_SW, I_ENC_DIR, I_ENC_STEP, I_NEG_LIM, I_POS_LIM, I_HOME_SW, I_INDEX};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_sync
      // a change counts only when stages two and three agree
      always @(posedge I_CORE_CLK or negedge I_RESETN)
      begin
        if (!I_RESETN)
        begin
          s1_r[gi]  <= 1'b0;
          s2_r[gi]  <= 1'b0;
          s3_r[gi]  <= 1'b0;
          pin_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi] <= pin_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi])
            pin_r[gi] <= s3_r[gi];
        end
      end
    end
  endgenerate

  reg  [5:0] prev_r;
  wire idx_f  = pin_r[0];
  wire home_f = pin_r[1];
  wire plim_f = pin_r[2];
  wire nlim_f = pin_r[3];
  wire idx_rise  = idx_f & ~prev_r[0];
  wire step_rise = pin_r[4] & ~prev_r[4];
  wire [7:0] node_octet = pin_r[13:6];

  // ******************************************
  // registers
  // ******************************************
  reg  [`HSQ_METH_W-1:0] meth_r;
  reg  [15:0]            fast_r;
  reg  [15:0]            slow_r;
  reg  [31:0]            home_r;
  reg  [4:0]             st_r;
  reg  [4:0]             st_nxt;
  reg                    dir_nxt;
  reg                    rev_r;
  wire                   start = I_WR && (I_ADDR == `HSQ_REG_CTRL) && I_WDATA[`HSQ_CTRL_START];

  always @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      meth_r  <= `HSQ_RST_METH;
      fast_r  <= `HSQ_RST_SPEED;
      slow_r  <= `HSQ_RST_SPEED;
      O_ACCEL <= `HSQ_RST_ACCEL;
      home_r  <= `HSQ_RST_HOME;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        `HSQ_REG_CTRL:
          meth_r <= I_WDATA[`HSQ_CTRL_METH_LSB +: `HSQ_METH_W];
        `HSQ_REG_FAST:
          fast_r <= I_WDATA[15:0];
        `HSQ_REG_SLOW:
          slow_r <= I_WDATA[15:0];
        `HSQ_REG_ACCEL:
          O_ACCEL <= I_WDATA[15:0];
        `HSQ_REG_HOME:
          home_r <= I_WDATA;
        default:
          home_r <= home_r;
      endcase
    end
  end

  // read data stand in the cycle after the strobe only
  always @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
      O_RDATA <= 32'h00000000;
    else if (!I_RD)
      O_RDATA <= 32'h00000000;
    else
    begin
      case (I_ADDR)
        `HSQ_REG_CTRL:
          O_RDATA <= {18'h00000, meth_r, 8'h00};
        `HSQ_REG_FAST:
          O_RDATA <= {16'h0000, fast_r};
        `HSQ_REG_SLOW:
          O_RDATA <= {16'h0000, slow_r};
        `HSQ_REG_ACCEL:
          O_RDATA <= {16'h0000, O_ACCEL};
        `HSQ_REG_HOME:
          O_RDATA <= home_r;
        `HSQ_REG_STATUS:
          O_RDATA <= {16'h0000, nlim_f, plim_f, home_f, idx_f, 3'h0, st_r,
                      O_MOVE_DIR, O_MOVE_EN, O_HOME_ERR, O_HOME_DONE};
        `HSQ_REG_POS:
          O_RDATA <= O_POSITION;
        `HSQ_REG_NODE:
          O_RDATA <= {`HSQ_IP_PREFIX, node_octet};
        default:
          O_RDATA <= 32'h00000000;
      endcase
    end
  end

  // ******************************************
  // method decode
  // ******************************************
  reg  [`HSQ_METH_W-1:0] base;
  reg                    m_ok;
  reg                    use_idx;
  reg                    set_only;
  reg  [1:0]             sw_sel;
  reg  [1:0]             lim_sel;
  reg                    d1;
  reg                    d2;
  reg                    skip_seek;
  always @*
  begin
    base      = meth_r;
    m_ok      = 1'b1;
    use_idx   = 1'b1;
    set_only  = 1'b0;
    sw_sel    = `HSQ_SW_NONE;
    lim_sel   = `HSQ_SW_NONE;
    d1        = 1'b0;
    d2        = 1'b0;
    skip_seek = 1'b0;
    if (meth_r >= `HSQ_M_NOIDX_MIN && meth_r <= `HSQ_M_NOIDX_MAX)
    begin
      base    = meth_r - `HSQ_NO_INDEX_OFS;
      use_idx = 1'b0;
    end
    case (base)
      6'h01:
      begin
        sw_sel = `HSQ_SW_NEG;
        d1     = 1'b0;
        d2     = 1'b1;
      end
      6'h02:
      begin
        sw_sel = `HSQ_SW_POS;
        d1     = 1'b1;
        d2     = 1'b0;
      end
      // start from switch level, fixed final direction
      6'h03, 6'h04:
      begin
        sw_sel = `HSQ_SW_HOME;
        d1     = home_f ^ (base == 6'h03);
        d2     = (base == 6'h04);
      end
      6'h05, 6'h06:
      begin
        sw_sel = `HSQ_SW_HOME;
        d1     = home_f ^ (base == 6'h06);
        d2     = (base == 6'h05);
      end
      // home switch edge with limit reversal
      6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e:
      begin
        sw_sel = `HSQ_SW_HOME;
        if (base <= 6'h0a)
        begin
          lim_sel = `HSQ_SW_POS;
          d1      = 1'b1;
        end
        else
        begin
          lim_sel = `HSQ_SW_NEG;
          d1      = 1'b0;
        end
        if (home_f)
          d1 = ~(base == 6'h07 || base == 6'h08 || base == 6'h0b || base == 6'h0c);
        // index left for odd, right for even
        d2 = ~base[0];
      end
      `HSQ_M_IDX_NEG, `HSQ_M_IDX_POS:
      begin
        skip_seek = 1'b1;
        d2        = (base == `HSQ_M_IDX_POS);
      end
      `HSQ_M_SET_POS:
        set_only = 1'b1;
      default:
        m_ok = 1'b0;
    endcase
  end

  // ******************************************
  // sequencer
  // ******************************************
  reg  sw_now;
  reg  sw_prev;
  reg  lim_now;
  always @*
  begin
    case (sw_sel)
      `HSQ_SW_NEG:
      begin
        sw_now  = nlim_f;
        sw_prev = prev_r[3];
      end
      `HSQ_SW_POS:
      begin
        sw_now  = plim_f;
        sw_prev = prev_r[2];
      end
      `HSQ_SW_HOME:
      begin
        sw_now  = home_f;
        sw_prev = prev_r[1];
      end
      default:
      begin
        sw_now  = 1'b0;
        sw_prev = 1'b0;
      end
    endcase
    case (lim_sel)
      `HSQ_SW_NEG:
        lim_now = nlim_f & ~prev_r[3];
      `HSQ_SW_POS:
        lim_now = plim_f & ~prev_r[2];
      default:
        lim_now = 1'b0;
    endcase
  end
  wire sw_edge = sw_now ^ sw_prev;
  wire capture = (st_r == ST_APPR) && (use_idx ? idx_rise : 1'b1);

  always @*
  begin
    st_nxt  = st_r;
    dir_nxt = O_MOVE_DIR;
    case (st_r)
      ST_IDLE, ST_DONE, ST_ERR:
      begin
        if (start)
        begin
          if (!m_ok)
            st_nxt = ST_ERR;
          else if (set_only)
            st_nxt = ST_DONE;
          else if (skip_seek)
          begin
            st_nxt  = ST_APPR;
            dir_nxt = d2;
          end
          else
          begin
            st_nxt  = ST_SEEK;
            dir_nxt = d1;
          end
        end
      end
      ST_SEEK:
      begin
        if (sw_edge)
        begin
          st_nxt  = ST_APPR;
          dir_nxt = d2;
        end
        // limit reached before the home edge: turn back
        else if (lim_now && !rev_r)
          dir_nxt = ~O_MOVE_DIR;
      end
      ST_APPR:
      begin
        if (capture)
          st_nxt = ST_DONE;
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  assign O_MOVE_EN = (st_r == ST_SEEK) || (st_r == ST_APPR);

  always @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      st_r        <= ST_IDLE;
      prev_r      <= 6'h00;
      rev_r       <= 1'b0;
      O_MOVE_DIR  <= 1'b0;
      O_SPEED     <= 16'h0000;
      O_POSITION  <= 32'h00000000;
      O_HOME_DONE <= 1'b0;
      O_HOME_ERR  <= 1'b0;
    end
    else
    begin
      st_r       <= st_nxt;
      prev_r     <= pin_r[5:0];
      O_MOVE_DIR <= dir_nxt;
      rev_r      <= (st_nxt == ST_SEEK) && (rev_r || (st_r == ST_SEEK && lim_now));
      // fast for switch, slow for index
      if (st_nxt == ST_SEEK)
        O_SPEED <= fast_r;
      else if (st_nxt == ST_APPR)
        O_SPEED <= slow_r;
      else
        O_SPEED <= 16'h0000;
      O_HOME_DONE <= (st_nxt == ST_DONE);
      O_HOME_ERR  <= (st_nxt == ST_ERR);
      // zero at home, overrun keeps counting
      if (capture)
        O_POSITION <= 32'h00000000;
      else if (start && m_ok && set_only && st_r != ST_SEEK && st_r != ST_APPR)
        O_POSITION <= home_r;
      else if (step_rise)
        O_POSITION <= pin_r[5] ? O_POSITION + 32'h00000001 : O_POSITION - 32'h00000001;
    end
  end
endmodule

// file: test/hsq_checker_asserts.sv
// checker: port relations of the homing sequencer
`timescale 1ns/1ps
`include "hsq_defines.vh"
module hsq_checker
(
  input wire        I_CORE_CLK,
  input wire        I_RESETN,
  input wire [7:0]  I_ADDR,
  input wire [31:0] I_WDATA,
  input wire        I_WR,
  input wire        I_RD,
  input wire [7:0]  I_NODE_SW,
  input wire [31:0] O_RDATA,
  input wire        O_MOVE_EN,
  input wire [15:0] O_SPEED,
  input wire [15:0] O_ACCEL,
  input wire [31:0] O_POSITION,
  input wire        O_HOME_DONE,
  input wire        O_HOME_ERR
);
  // node pins need a few quiet cycles to pass the pin filter
  reg [7:0] node_q;
  reg [2:0] node_age;
  always @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      node_q   <= 8'h00;
      node_age <= 3'h0;
    end
    else
    begin
      node_q <= I_NODE_SW;
      if (I_NODE_SW != node_q)
        node_age <= 3'h0;
      else if (node_age != 3'h7)
        node_age <= node_age + 3'h1;
    end
  end
  // ****
  // assertions
  // ****
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  AST_DONE_STILL: assert property (O_HOME_DONE |-> !O_MOVE_EN)
    else $error("motion while done");
  AST_ERR_STILL: assert property (O_HOME_ERR |-> !O_MOVE_EN && !O_HOME_DONE)
    else $error("motion or done while rejected");
  AST_ERR_FAST: assert property ($rose(O_HOME_ERR) |-> !$past(O_MOVE_EN))
    else $error("reserved method moved");
  AST_DONE_FALL: assert property ($fell(O_HOME_DONE) |-> $past(I_WR) &&
    $past(I_ADDR) == `HSQ_REG_CTRL && $past(I_WDATA[0])) else $error("done dropped");
  AST_START_MOVE: assert property ($rose(O_MOVE_EN) |-> $past(I_WR) &&
    $past(I_ADDR) == `HSQ_REG_CTRL && $past(I_WDATA[0])) else $error("motion unasked");
  AST_SPEED_IDLE: assert property (!O_MOVE_EN |-> O_SPEED == 16'h0000)
    else $error("speed without motion");
  AST_ACCEL_VAL: assert property ($past(I_WR) && $past(I_ADDR) == `HSQ_REG_ACCEL
    |-> O_ACCEL == $past(I_WDATA[15:0])) else $error("accel not taken");
  AST_ACCEL_HOLD: assert property (!$stable(O_ACCEL) |-> $past(I_WR) &&
    $past(I_ADDR) == `HSQ_REG_ACCEL) else $error("accel moved alone");
  AST_RD_NODE: assert property ($past(I_RD) && $past(I_ADDR) == `HSQ_REG_NODE
    && $past(node_age) >= 3'h3 |-> O_RDATA == {`HSQ_IP_PREFIX, $past(I_NODE_SW)})
    else $error("bad node address");
  AST_POS_ZERO: assert property ($rose(O_HOME_DONE) && $past(O_MOVE_EN)
    |-> O_POSITION == 32'h0) else $error("position not zeroed");
endmodule

// file: test/hsq_axis_model.sv
// axis model: load with encoder, index every 16 units and switches
`timescale 1ns/1ps
module hsq_axis_model
(
  input  wire i_clk,
  input  wire i_move_en,
  input  wire i_move_dir,
  output reg  o_step,
  output reg  o_dir,
  output wire o_index,
  output wire o_home_sw,
  output wire o_pos_lim,
  output wire o_neg_lim
);
  integer pos = 5;
  integer ph = 0;
  assign o_neg_lim = pos <= -30;
  assign o_pos_lim = pos >= 30;
  // home region sits between the limits so every switch method can reach it
  assign o_home_sw = pos >= 10 && pos <= 24;
  // index held a full step so the pin filter sees it
  assign o_index = pos % 16 == 0;
  initial o_step = 1'b0;
  initial o_dir = 1'b1;
  // one step per 8 cycles, only while motion is requested
  always @(posedge i_clk)
  begin
    ph <= (ph + 1) % 8;
    if (ph == 4)
      o_step <= 1'b0;
    if (ph == 7 && i_move_en)
    begin
      o_dir <= i_move_dir;
      o_step <= 1'b1;
      pos <= pos + (i_move_dir ? 1 : -1);
    end
  end
endmodule

// file: test/tb_homing_sequencer.sv
// testbench: homing sequencer driving a simulated axis
`timescale 1ns/1ps
`include "hsq_defines.vh"
`define CHK(n,e,s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_homing_sequencer;
  reg         I_CORE_CLK, I_RESETN, I_WR, I_RD;
  reg  [7:0]  I_ADDR, I_NODE_SW;
  reg  [31:0] I_WDATA, q, lfsr;
  reg  [31:0] rv [0:3];
  wire [31:0] O_RDATA, O_POSITION;
  wire [15:0] O_SPEED, O_ACCEL;
  wire        O_MOVE_EN, O_MOVE_DIR, O_HOME_DONE, O_HOME_ERR;
  wire        idx, hsw, plim, nlim, stp, sdir;
  integer     fail_count = 0, n_tests = 0, cyc = 0, i, k;
  int         mt [12] = '{1, 2, 17, 18, 33, 34, 3, 19, 7, 8, 7, 9};
  int         eh [12] = '{-16, 16, -30, 30, 0, 16, 0, 10, 0, 16, 0, 16};
  int         sp [12] = '{5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 15, 15};
  int         ed [12] = '{0, 1, 0, 1, 0, 1, 1, 1, 1, 1, 0, 1};
  int         bad [7] = '{0, 15, 16, 31, 32, 36, 63};
  hsq_homing_sequencer uut (.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_INDEX(idx), .I_HOME_SW(hsw), .I_POS_LIM(plim), .I_NEG_LIM(nlim),
    .I_ENC_STEP(stp), .I_ENC_DIR(sdir), .I_NODE_SW(I_NODE_SW), .O_MOVE_EN(O_MOVE_EN),
    .O_MOVE_DIR(O_MOVE_DIR), .O_SPEED(O_SPEED), .O_ACCEL(O_ACCEL),
    .O_POSITION(O_POSITION), .O_HOME_DONE(O_HOME_DONE), .O_HOME_ERR(O_HOME_ERR));
  hsq_axis_model ax (.i_clk(I_CORE_CLK), .i_move_en(O_MOVE_EN), .i_move_dir(O_MOVE_DIR),
    .o_step(stp), .o_dir(sdir), .o_index(idx), .o_home_sw(hsw), .o_pos_lim(plim),
    .o_neg_lim(nlim));
  // ****
  // helpers
  // ****
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge I_CORE_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CORE_CLK);
    I_WR <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge I_CORE_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CORE_CLK);
    I_RD <= 1'b0;
    #1 q = O_RDATA;
  end
  endtask
  // method written first: a start in the same write uses the old one
  task run(input [5:0] m);
  begin
    wr(`HSQ_REG_CTRL, {18'h0, m, 8'h00});
    wr(`HSQ_REG_CTRL, {18'h0, m, 8'h01});
    @(posedge I_CORE_CLK);
    #1;
  end
  endtask
  task end_of_test;
  begin
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  initial
  begin
    I_CORE_CLK = 1'b0;
    forever #50 I_CORE_CLK = ~I_CORE_CLK;
  end
  // hang guard, runs need a few thousand cycles
  always @(posedge I_CORE_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test;
    end
  end
  // ****
  // scenarios
  // ****
  initial
  begin
    I_RESETN = 1'b0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    I_ADDR = 8'h00;
    I_WDATA = 32'h0;
    lfsr = 32'h158a073e;
    I_NODE_SW = lfsr[7:0];
    repeat (4) @(posedge I_CORE_CLK);
    I_RESETN <= 1'b1;
    rd(`HSQ_REG_STATUS);
    `CHK("status", 32'h10, q)
    rd(8'h20);
    `CHK("unmapped", 32'h0, q)
    // node pins are readable only once the pin filter has passed them
    rd(`HSQ_REG_NODE);
    `CHK("node", {24'hc0a864, I_NODE_SW}, q)
    for (i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      rv[i] = i == 3 ? lfsr : lfsr & 32'h0000ffff;
      wr(8'(4 + 4 * i), lfsr);
    end
    for (i = 0; i < 4; i++)
    begin
      rd(8'(4 + 4 * i));
      `CHK("reg", rv[i], q)
    end
    `CHK("accel", rv[2][15:0], O_ACCEL)
    run(6'd35);
    `CHK("m35 pos", rv[3], O_POSITION)
    `CHK("m35 done", 1'b1, O_HOME_DONE)
    for (i = 0; i < 7; i++)
    begin
      run(6'(bad[i]));
      `CHK("reject", 1'b1, O_HOME_ERR)
    end
    rd(`HSQ_REG_STATUS);
    `CHK("err status", 32'h102, q & 32'hfffffff7)
    for (k = 0; k < 12; k++)
    begin
      ax.pos = sp[k];
      repeat (8) @(posedge I_CORE_CLK);
      run(6'(mt[k]));
      `CHK("dir", ed[k], O_MOVE_DIR)
      `CHK("speed", mt[k] > 32 ? rv[1][15:0] : rv[0][15:0], O_SPEED)
      while (O_HOME_DONE !== 1'b1 && O_HOME_ERR !== 1'b1)
      begin
        @(posedge I_CORE_CLK);
        #1;
      end
      `CHK("done", 1'b1, O_HOME_DONE)
      `CHK("home", eh[k], ax.pos)
      `CHK("pos", 32'(ax.pos - eh[k]), O_POSITION)
    end
    end_of_test;
  end
endmodule
bind hsq_homing_sequencer hsq_checker chk (.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_NODE_SW(I_NODE_SW),
  .O_RDATA(O_RDATA), .O_MOVE_EN(O_MOVE_EN), .O_SPEED(O_SPEED), .O_ACCEL(O_ACCEL),
  .O_POSITION(O_POSITION), .O_HOME_DONE(O_HOME_DONE), .O_HOME_ERR(O_HOME_ERR));
